// ==== verilog/slf_pkg.sv ====
// constants of the line framer
package slf_pkg;
    // ==================================================
    // register map
    localparam logic [3:0]  REG_CTRL      = 4'h0;
    localparam logic [3:0]  REG_STATUS    = 4'h4;
    localparam logic [3:0]  REG_MASK      = 4'h8;
    localparam logic [3:0]  REG_STATE     = 4'hc;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    localparam int          CTRL_W        = 16;
    localparam logic [15:0] CTRL_RESET    = 16'h0000;
    localparam int          CB_FORMAT     = 0;
    localparam int          CB_SYNTH_BYP  = 1;
    localparam int          CB_LOOP       = 2;
    localparam int          CB_RECOV_BYP  = 3;
    localparam int          CB_FAC_LB     = 4;
    localparam int          CB_TERM_LB    = 5;
    localparam int          CB_LINE_FERF  = 6;
    localparam int          CB_PATH_FERF  = 7;
    localparam int          CB_PATH_RDI   = 8;
    localparam int          CB_B3_LSB     = 12;
    localparam int          ST_W          = 3;
    localparam int          ST_OPT_LOSS   = 0;
    localparam int          ST_FRAME_ACQ  = 1;
    localparam int          ST_FRAME_LOST = 2;
    localparam logic [2:0]  STATUS_RESET  = 3'h0;
    // ==================================================
    // synchroniser lanes
    localparam int          SYNC_W        = 6;
    localparam int          SI_REF        = 0;
    localparam int          SI_TXEXT      = 1;
    localparam int          SI_RREC       = 2;
    localparam int          SI_REXT       = 3;
    localparam int          SI_RDAT       = 4;
    localparam int          SI_LOSS       = 5;
    // ==================================================
    // frame geometry and overhead values
    localparam logic [3:0]  LAST_ROW      = 4'd8;
    localparam logic [8:0]  LAST_COL      = 9'd269;
    localparam logic [8:0]  POH_COL       = 9'd9;
    localparam logic [8:0]  PAY_COL       = 9'd12;
    localparam logic [8:0]  TOH_COLS      = 9'd9;
    localparam logic [8:0]  HUNT_COL      = 9'd6;
    localparam logic [8:0]  LAST_A2_COL   = 9'd5;
    localparam logic [7:0]  A1_BYTE       = 8'hf6;
    localparam logic [7:0]  A2_BYTE       = 8'h28;
    localparam logic [47:0] FRAME_PATTERN = 48'hf6f6f6282828;
    localparam logic [7:0]  C1_FIRST      = 8'h01;
    localparam logic [7:0]  C1_2_SONET    = 8'h02;
    localparam logic [7:0]  C1_3_SONET    = 8'h03;
    localparam logic [7:0]  C1_REST_SDH   = 8'h00;
    localparam logic [7:0]  H1_1_SONET    = 8'h62;
    localparam logic [7:0]  H1_1_SDH      = 8'h6a;
    localparam logic [7:0]  H1_N_SONET    = 8'h93;
    localparam logic [7:0]  H1_N_SDH      = 8'h9b;
    localparam logic [7:0]  H2_FIRST      = 8'h0a;
    localparam logic [7:0]  H2_REST       = 8'hff;
    localparam logic [7:0]  K2_LINE_FERF  = 8'h06;
    localparam logic [7:0]  C2_LABEL      = 8'h13;
    localparam logic [3:0]  G1_PATH_FERF  = 4'h9;
    localparam logic [7:0]  IDLE_PAYLOAD  = 8'h6a;
    localparam logic [6:0]  SCR_SEED      = 7'h7f;
endpackage : slf_pkg

// ==== verilog/slf_line_framer.sv ====
// line framer: tx overhead, scrambler, serialiser, rx retiming and frame hunt
// How it works
// - scramble frame with x^7+x^6+1
// - A1, A2, C1 bytes go out unscrambled
// - scrambler seeds all ones after third C1
// - scrambler steps every byte, never pauses
// - scrambled bytes shift out serially
// - two selects choose tx clock source
// - data launched on rising true clock
// - terminal loopback routes tx cells to rx
// - bypass uses external rx clock
// - rx data retimed to recovered clock
// - facility loopback drives tx from rx
// - optical loss sets flag, interrupt low
// - framer hunts F6h and 28h bytes
// - align only on full six-byte pattern
// - loop timing clocks tx from rx
// - format select picks SONET or SDH
// - B1 is BIP-8 of previous scrambled frame
`timescale 1ns/10ps
`default_nettype none
module slf_line_framer (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        tx_reference_clock,
    input  wire logic        tx_fast_clock_true,
    input  wire logic        rx_recovered_clock,
    input  wire logic        rx_ext_clock,
    input  wire logic        rx_serial_true,
    input  wire logic        optical_loss_flag_true,
    input  wire logic        optical_loss_flag_comp,
    input  wire logic [7:0]  tx_cell_data,
    input  wire logic        tx_cell_valid,
    output logic             tx_cell_take,
    output logic             tx_serial_true,
    output logic             tx_serial_comp,
    output logic             tx_fast_clock_out,
    output logic             tx_fast_clock_comp,
    output logic [7:0]       rx_cell_data,
    output logic             rx_cell_valid,
    output logic             frame_locked,
    output logic             interrupt_n
);
    import slf_pkg::*;

    // returns {state after 8 steps, keystream byte msb first}
    function automatic logic [14:0] scr8(input logic [6:0] s);
        logic [6:0] st;
        logic [7:0] k;
        st = s;
        k  = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            k[i] = st[6];
            st   = {st[5:0], st[6] ^ st[5]};
        end
        return {st, k};
    endfunction : scr8

    function automatic logic [6:0] scr_step(input logic [6:0] s);
        logic [14:0] r;
        r = scr8(s);
        return r[14:8];
    endfunction : scr_step

    // ==================================================
    // synchronisers and edge finding
    logic [SYNC_W-1:0] sync1, sync2, sync3;
    logic [SYNC_W-1:0] raw_in;
    assign raw_in = {optical_loss_flag_true, rx_serial_true,
                     rx_ext_clock, rx_recovered_clock, tx_fast_clock_true,
                     tx_reference_clock};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= raw_in;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // comp pin retimed on its own; pins combine only after both are retimed
    logic [1:0] loss_comp;
    logic       loss_level;
    always_ff @(posedge aclk) begin
        if (!aresetn) loss_comp <= 2'b11;
        else loss_comp <= {loss_comp[0], optical_loss_flag_comp};
    end
    assign loss_level = sync2[SI_LOSS] & ~loss_comp[1];

    logic [CTRL_W-1:0] ctrl;
    logic              rx_clk_now, rx_clk_prev, rx_rise;
    logic              tx_src_now, tx_src_prev, tx_rise;
    logic              fac_lb, term_lb;
    assign fac_lb      = ctrl[CB_FAC_LB];
    assign term_lb     = ctrl[CB_TERM_LB];
    assign rx_clk_now  = ctrl[CB_RECOV_BYP] ? sync2[SI_REXT] : sync2[SI_RREC];
    assign rx_clk_prev = ctrl[CB_RECOV_BYP] ? sync3[SI_REXT] : sync3[SI_RREC];
    assign rx_rise     = rx_clk_now & ~rx_clk_prev;
    always_comb begin
        // loop timing: losing rx clock also stops tx
        if (ctrl[CB_SYNTH_BYP]) begin
            tx_src_now  = sync2[SI_TXEXT];
            tx_src_prev = sync3[SI_TXEXT];
        end else if (ctrl[CB_LOOP]) begin
            tx_src_now  = rx_clk_now;
            tx_src_prev = rx_clk_prev;
        end else begin
            tx_src_now  = sync2[SI_REF];
            tx_src_prev = sync3[SI_REF];
        end
    end
    assign tx_rise = tx_src_now & ~tx_src_prev;

    // ==================================================
    // transmit frame builder
    logic [3:0] tx_row;
    logic [8:0] tx_col;
    logic [2:0] tx_bit;
    logic [7:0] tx_shift, raw_byte, out_byte, b1_acc, b1_prev;
    logic [6:0] tx_scr, scr_cur;
    logic [14:0] scr_res;
    logic       byte_load, seed_pos, clear_oh, is_pay, launch_bit, sdh;
    assign sdh       = ctrl[CB_FORMAT];
    assign byte_load = tx_rise && (tx_bit == 3'd0);
    assign seed_pos  = (tx_row == 4'd0) && (tx_col == POH_COL);
    assign clear_oh  = (tx_row == 4'd0) && (tx_col < TOH_COLS);
    assign is_pay    = tx_col >= PAY_COL;
    assign scr_cur   = seed_pos ? SCR_SEED : tx_scr;
    assign scr_res   = scr8(scr_cur);
    assign out_byte  = clear_oh ? raw_byte : raw_byte ^ scr_res[7:0];
    assign launch_bit = (tx_bit == 3'd0) ? out_byte[7] : tx_shift[7];

    always_comb begin
        raw_byte = 8'h00;
        if (is_pay) begin
            raw_byte = tx_cell_valid ? tx_cell_data : IDLE_PAYLOAD;
        end else if (tx_col == POH_COL) begin
            if (tx_row == 4'd2) raw_byte = C2_LABEL;
            if (tx_row == 4'd3) raw_byte = {ctrl[CB_PATH_FERF] ? G1_PATH_FERF
                                            : ctrl[CB_B3_LSB +: 4], ctrl[CB_PATH_RDI], 3'b000};
        end else if (tx_col < TOH_COLS) begin
            case (tx_row)
                4'd0: begin
                    if (tx_col < 9'd3)      raw_byte = A1_BYTE;
                    else if (tx_col < 9'd6) raw_byte = A2_BYTE;
                    else if (tx_col == 9'd6) raw_byte = C1_FIRST;
                    else if (tx_col == 9'd7) raw_byte = sdh ? C1_REST_SDH : C1_2_SONET;
                    else raw_byte = sdh ? C1_REST_SDH : C1_3_SONET;
                end
                4'd1: raw_byte = (tx_col == 9'd0) ? b1_prev : 8'h00;
                4'd3: begin
                    if (tx_col == 9'd0)      raw_byte = sdh ? H1_1_SDH : H1_1_SONET;
                    else if (tx_col < 9'd3)  raw_byte = sdh ? H1_N_SDH : H1_N_SONET;
                    else if (tx_col == 9'd3) raw_byte = H2_FIRST;
                    else if (tx_col < 9'd6)  raw_byte = H2_REST;
                    else raw_byte = 8'h00;
                end
                4'd4: begin
                    if (tx_col == 9'd6 && ctrl[CB_LINE_FERF]) raw_byte = K2_LINE_FERF;
                end
                default: raw_byte = 8'h00;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_row   <= 4'd0;
            tx_col   <= 9'd0;
            tx_bit   <= 3'd0;
            tx_shift <= 8'h00;
            tx_scr   <= SCR_SEED;
        end else if (tx_rise) begin
            tx_bit <= tx_bit + 3'd1;
            if (byte_load) begin
                tx_shift <= {out_byte[6:0], 1'b0};
                tx_scr   <= scr_res[14:8];
                if (tx_col == LAST_COL) begin
                    tx_col <= 9'd0;
                    tx_row <= (tx_row == LAST_ROW) ? 4'd0 : tx_row + 4'd1;
                end else begin
                    tx_col <= tx_col + 9'd1;
                end
            end else begin
                tx_shift <= {tx_shift[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            b1_acc  <= 8'h00;
            b1_prev <= 8'h00;
        end else if (byte_load) begin
            if (tx_row == LAST_ROW && tx_col == LAST_COL) begin
                b1_prev <= b1_acc ^ out_byte;
                b1_acc  <= 8'h00;
            end else begin
                b1_acc <= b1_acc ^ out_byte;
            end
        end
    end

    // both modes move data and clock out in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_serial_true     <= 1'b0;
            tx_serial_comp     <= 1'b1;
            tx_fast_clock_out  <= 1'b0;
            tx_fast_clock_comp <= 1'b1;
        end else if (fac_lb) begin
            tx_fast_clock_out  <= rx_clk_now;
            tx_fast_clock_comp <= ~rx_clk_now;
            if (rx_rise) begin
                tx_serial_true <= sync2[SI_RDAT];
                tx_serial_comp <= ~sync2[SI_RDAT];
            end
        end else begin
            tx_fast_clock_out  <= tx_src_now;
            tx_fast_clock_comp <= ~tx_src_now;
            if (tx_rise) begin
                tx_serial_true <= launch_bit;
                tx_serial_comp <= ~launch_bit;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) tx_cell_take <= 1'b0;
        else tx_cell_take <= byte_load && is_pay && tx_cell_valid;
    end

    // ==================================================
    // receive retiming and frame hunt
    logic [47:0] hunt, next_hunt;
    logic [3:0]  rx_row;
    logic [8:0]  rx_col;
    logic [2:0]  rx_bit;
    logic [7:0]  rx_byte;
    logic [6:0]  rx_scr, rx_cur;
    logic [14:0] rx_res;
    logic        rx_byte_done, ev_acq, ev_lost;
    assign next_hunt    = {hunt[46:0], sync2[SI_RDAT]};
    assign rx_byte_done = rx_rise && frame_locked && (rx_bit == 3'd7);
    assign rx_cur       = (rx_row == 4'd0 && rx_col == POH_COL) ? SCR_SEED : rx_scr;
    assign rx_res       = scr8(rx_cur);
    assign ev_acq       = rx_rise && !frame_locked && (next_hunt == FRAME_PATTERN);
    assign ev_lost      = rx_byte_done && rx_row == 4'd0 && rx_col == LAST_A2_COL
                          && next_hunt != FRAME_PATTERN;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hunt         <= 48'h0;
            frame_locked <= 1'b0;
            rx_row       <= 4'd0;
            rx_col       <= 9'd0;
            rx_bit       <= 3'd0;
            rx_byte      <= 8'h00;
            rx_scr       <= SCR_SEED;
        end else if (rx_rise) begin
            hunt    <= next_hunt;
            rx_byte <= next_hunt[7:0];
            if (ev_acq) begin
                frame_locked <= 1'b1;
                rx_row       <= 4'd0;
                rx_col       <= HUNT_COL;
                rx_bit       <= 3'd0;
            end else if (frame_locked) begin
                rx_bit <= rx_bit + 3'd1;
                if (ev_lost) frame_locked <= 1'b0;
                if (rx_bit == 3'd7) begin
                    rx_scr <= rx_res[14:8];
                    if (rx_col == LAST_COL) begin
                        rx_col <= 9'd0;
                        rx_row <= (rx_row == LAST_ROW) ? 4'd0 : rx_row + 4'd1;
                    end else begin
                        rx_col <= rx_col + 9'd1;
                    end
                end
            end
        end
    end

    // terminal loopback blocks line cells entirely
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_cell_data  <= 8'h00;
            rx_cell_valid <= 1'b0;
        end else if (term_lb) begin
            rx_cell_data  <= tx_cell_data;
            rx_cell_valid <= byte_load && is_pay && tx_cell_valid;
        end else begin
            rx_cell_data  <= next_hunt[7:0] ^ rx_res[7:0];
            rx_cell_valid <= rx_byte_done && rx_col >= PAY_COL;
        end
    end

    // ==================================================
    // status, mask, interrupt
    logic [ST_W-1:0] status, mask, events, w1c;
    assign events = {ev_lost, ev_acq, loss_level};
    always_ff @(posedge aclk) begin
        if (!aresetn) status <= STATUS_RESET;
        else status <= (status & ~w1c) | events;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) interrupt_n <= 1'b1;
        else interrupt_n <= ~|(status & mask);
    end

    // ==================================================
    // axi4-lite slave; write address and data may arrive in either order
    logic        aw_have, w_have;
    logic [3:0]  aw_addr;
    logic [31:0] w_data, bmask;
    logic [3:0]  w_strb;
    logic        do_write;
    assign do_write = aw_have && w_have && !s_axi_bvalid;
    assign bmask    = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    assign w1c      = (do_write && aw_addr == REG_STATUS) ? w_data[ST_W-1:0] & bmask[ST_W-1:0]
                                                          : '0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have       <= 1'b0;
            w_have        <= 1'b0;
            aw_addr       <= 4'h0;
            w_data        <= 32'h0;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_have && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_have && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_have      <= 1'b0;
                w_have       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr == REG_CTRL || aw_addr == REG_STATUS
                                 || aw_addr == REG_MASK) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= CTRL_RESET;
            mask <= '0;
        end else if (do_write) begin
            if (aw_addr == REG_CTRL) ctrl <= (ctrl & ~bmask[CTRL_W-1:0]) | (w_data[CTRL_W-1:0]
                                                                   & bmask[CTRL_W-1:0]);
            if (aw_addr == REG_MASK) mask <= (mask & ~bmask[ST_W-1:0]) | (w_data[ST_W-1:0]
                                                                   & bmask[ST_W-1:0]);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= RESP_OKAY;
                case (s_axi_araddr)
                    REG_CTRL:   s_axi_rdata <= {16'h0, ctrl};
                    REG_STATUS: s_axi_rdata <= {29'h0, status};
                    REG_MASK:   s_axi_rdata <= {29'h0, mask};
                    REG_STATE:  s_axi_rdata <= {30'h0, loss_level, frame_locked};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==================================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_seed_load;
        byte_load && seed_pos;
    endsequence
    sequence s_tx_launch;
        tx_rise && !fac_lb;
    endsequence
    property p_seed;
        s_seed_load |=> tx_scr == scr_step(SCR_SEED);
    endproperty
    a_seed: assert property (p_seed) else $error("scrambler not seeded");
    property p_run;
        byte_load && !seed_pos |=> tx_scr == scr_step($past(tx_scr));
    endproperty
    a_run: assert property (p_run) else $error("scrambler skipped a byte");
    property p_clear;
        byte_load && clear_oh |=> tx_shift == {$past(raw_byte[6:0]), 1'b0};
    endproperty
    a_clear: assert property (p_clear) else $error("framing byte scrambled");
    property p_launch;
        s_tx_launch |=> tx_serial_true == $past(launch_bit) && tx_fast_clock_out;
    endproperty
    a_launch: assert property (p_launch) else $error("bit not launched on edge");
    property p_fac;
        fac_lb && rx_rise |=> tx_serial_true == $past(sync2[SI_RDAT]);
    endproperty
    a_fac: assert property (p_fac) else $error("facility loopback wrong");
    property p_loss;
        loss_level && mask[ST_OPT_LOSS] |-> ##2 !interrupt_n;
    endproperty
    a_loss: assert property (p_loss) else $error("loss did not interrupt");
    property p_acq;
        ev_acq |=> frame_locked && rx_col == HUNT_COL && rx_bit == 3'd0 ##0 status[ST_FRAME_ACQ];
    endproperty
    a_acq: assert property (p_acq) else $error("frame not acquired");
    property p_term;
        term_lb |=> !rx_cell_valid || $past(tx_cell_valid);
    endproperty
    a_term: assert property (p_term) else $error("line cell leaked");
    property p_c1;
        byte_load && tx_row == 4'd0 && tx_col == 9'd7
            |=> tx_shift[7:1] == ($past(sdh) ? C1_REST_SDH[6:0] : C1_2_SONET[6:0]);
    endproperty
    a_c1: assert property (p_c1) else $error("c1 format wrong");
endmodule : slf_line_framer
`default_nettype wire

// ==== dv/slf_optic_model.sv ====
// optical transceiver model: line data, recovered clock, loss flags
`timescale 1ns/10ps
`default_nettype none
module slf_optic_model
    import slf_pkg::*;
(
    input  wire logic clk_link,
    input  wire logic run,
    input  wire logic lost,
    output logic      rx_recovered_clock,
    output logic      rx_serial_true,
    output logic      optical_loss_flag_true,
    output logic      optical_loss_flag_comp
);
    import slf_pkg::*;
    int   i = 0;
    logic t = 1'b0;
    logic on = 1'b0;
    // clock stands still while run is low; run taken on a falling edge, no clipped pulse
    assign rx_recovered_clock = on & clk_link;
    // idle line toggles, so a stale level never looks like data
    assign rx_serial_true = (on && i < 48) ? FRAME_PATTERN[47 - i] : t;
    assign optical_loss_flag_true = lost;
    assign optical_loss_flag_comp = ~lost;
    always @(negedge clk_link) begin
        t <= ~t;
        on <= run;
        if (on) begin
            i <= i + 1;
        end
    end
endmodule : slf_optic_model
`default_nettype wire

// ==== dv/slf_line_framer_test.sv ====
// self-checking bench of the line framer
`timescale 1ns/10ps
`default_nettype none
module slf_line_framer_test;
    import slf_pkg::*;
    logic aclk = 0, aresetn = 0, tx_reference_clock = 0, lnk = 0, run = 0, lost = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, tx_cell_valid = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, tx_serial_true, tx_serial_comp, tx_fast_clock_out;
    logic tx_fast_clock_comp, rx_recovered_clock, rx_serial_true, optical_loss_flag_true;
    logic optical_loss_flag_comp, rx_cell_valid, frame_locked, interrupt_n;
    logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, s;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [7:0]  tx_cell_data = 0, rx_cell_data, tcd_q;
    logic [79:0] v;
    int          error_cnt = 0, n_compared = 0, cyc = 0, k;
    slf_line_framer dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_reference_clock,
        .tx_fast_clock_true(1'b0), .rx_recovered_clock, .rx_ext_clock(1'b0), .rx_serial_true,
        .optical_loss_flag_true, .optical_loss_flag_comp, .tx_cell_data, .tx_cell_valid,
        .tx_cell_take(), .tx_serial_true, .tx_serial_comp, .tx_fast_clock_out,
        .tx_fast_clock_comp, .rx_cell_data, .rx_cell_valid, .frame_locked, .interrupt_n);
    slf_optic_model opt_u (.clk_link(lnk), .run, .lost, .rx_recovered_clock,
        .rx_serial_true, .optical_loss_flag_true, .optical_loss_flag_comp);
    initial forever #12.5 aclk = ~aclk;
    initial begin
        #37;
        forever #100 lnk = ~lnk;
    end
    initial begin
        @(posedge aresetn);
        #5;
        forever #100 tx_reference_clock = ~tx_reference_clock;
    end
    always @(posedge aclk) begin
        tx_cell_data <= 8'($urandom);
        tx_cell_valid <= 1'($urandom);
        tcd_q <= tx_cell_data;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    // ==================================================
    // helpers
    function automatic logic [7:0] scr0();
        logic [6:0] q;
        logic [7:0] o;
        q = SCR_SEED;
        for (int i = 0; i < 8; i++) begin
            o = {o[6:0], q[6]};
            q = {q[5:0], q[6] ^ q[5]};
        end
        return o;
    endfunction : scr0
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] x);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= x;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
    endtask : rd
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude
    // ==================================================
    // tests
    initial begin
        logic p;
        void'($urandom(32'hc652));
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        p = 0;
        k = 0;
        // first ten bytes of the frame, one bit per rising clock out
        while (k < 80) begin
            @(posedge aclk);
            if (tx_fast_clock_out && !p) begin
                v = {v[78:0], tx_serial_true};
                k++;
            end
            p = tx_fast_clock_out;
        end
        chk(v[79:8], {FRAME_PATTERN, C1_FIRST, C1_2_SONET, C1_3_SONET});
        chk(v[7:0], scr0());
        chk({tx_fast_clock_comp, tx_serial_comp}, {!tx_fast_clock_out, !tx_serial_true});
        $display("test tx done");
        for (k = 0; k < 16; k += 4) begin
            rd(4'(k));
            chk({r, d}, {RESP_OKAY, 32'h0});
        end
        rd(4'h6);
        chk(r, RESP_SLVERR);
        s = $urandom & 32'hf1c0;
        wr(REG_CTRL, s);
        rd(REG_CTRL);
        chk(d, s);
        $display("test regs done");
        lost <= 1;
        repeat (8) @(posedge aclk);
        chk(interrupt_n, 1'b1);
        rd(REG_STATUS);
        chk(d[ST_OPT_LOSS], 1'b1);
        wr(REG_MASK, 32'h1);
        repeat (4) @(posedge aclk);
        chk(interrupt_n, 1'b0);
        lost <= 0;
        repeat (6) @(posedge aclk);
        wr(REG_STATUS, 32'h1);
        repeat (4) @(posedge aclk);
        chk({interrupt_n, dut_u.interrupt_n}, 2'b11);
        $display("test irq done");
        chk(frame_locked, 1'b0);
        run <= 1;
        k = 0;
        while (frame_locked !== 1'b1 && k < 1500) begin
            @(posedge aclk);
            k++;
        end
        chk(frame_locked, 1'b1);
        // no lock before the sixth framing byte has arrived
        chk(k > 360, 1'b1);
        rd(REG_STATUS);
        chk(d[ST_FRAME_ACQ], 1'b1);
        $display("test rx done");
        wr(REG_CTRL, 32'h20);
        k = 0;
        while (rx_cell_valid !== 1'b1 && k < 1000) begin
            @(posedge aclk);
            k++;
        end
        chk({rx_cell_valid, rx_cell_data}, {1'b1, tcd_q});
        $display("test loop done");
        conclude();
    end
endmodule : slf_line_framer_test
`default_nettype wire
